// File: hdl/tdm_pkg.sv
// package: register map, field positions, timing constants, carrier structs
`default_nettype none
package tdm_pkg;
    // register indices (printed offsets are not all multiples of four)
    localparam logic [7:0] IDX_SLOT_A_MODE = 8'h42;
    localparam logic [7:0] IDX_SLOT_A_ROUTE = 8'h43;
    localparam logic [7:0] IDX_SLOT_B_MODE = 8'h44;
    localparam logic [7:0] IDX_SLOT_B_ROUTE = 8'h45;
    localparam logic [7:0] IDX_MATH_CTRL = 8'h58;
    localparam logic [7:0] IDX_STATUS = 8'h60;
    localparam logic [7:0] IDX_SLOT_CTRL = 8'h61;
    // routing codes
    localparam logic [15:0] ROUTE_NORMAL = 16'hADA5;
    localparam logic [15:0] ROUTE_BYP_BPF = 16'hAE65;
    localparam logic [15:0] ROUTE_BYP_ALL = 16'hB065;
    // field positions
    localparam int BIT_INT_AS_BUF = 7;
    localparam int BIT_BUF_GAIN = 9;
    localparam int BIT_BIAS_LO = 4;
    localparam int BIT_ENA_BUF = 7;
    // reset values
    localparam logic [15:0] RST_MODE = 16'h1C00;
    localparam logic [15:0] RST_ROUTE = 16'hADA5;
    localparam logic [15:0] RST_MATH = 16'h0000;
    // timing
    localparam int CLK_MHZ = 200;
    localparam int CH_SPACING_US = 1;
    localparam int CH_SPACING_CYC = CH_SPACING_US * CLK_MHZ;
    localparam int NUM_CH = 4;

    typedef enum logic [1:0] {
        PATH_NORMAL = 2'b00,
        PATH_BYP_BPF = 2'b01,
        PATH_BYP_ALL = 2'b10
    } tdm_path_e;

    typedef struct packed {
        tdm_path_e path;
        logic int_as_buf;
        logic gain_07;
        logic [1:0] bias_sel;
        logic direct;
    } tdm_slot_cfg_s;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_CONV = 2'b01,
        SEQ_GAP = 2'b10
    } tdm_seq_e;
endpackage : tdm_pkg
`default_nettype wire

// File: hdl/tdm_chan_seq.sv
// channel sequencer: four conversions spaced one microsecond apart
`default_nettype none
module tdm_chan_seq
    import tdm_pkg::*;
#(
    parameter int SPACING = CH_SPACING_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    output logic busy,
    output logic conv_strobe,
    output logic [1:0] conv_chan
);
    initial begin
        if (SPACING < 1 || SPACING > 65535) begin
            $error("spacing out of range");
        end
    end

    typedef struct packed {
        tdm_seq_e st;
        logic [15:0] cnt;
        logic [1:0] ch;
        logic stb;
    } tdm_seq_s;

    tdm_seq_s s_q;
    tdm_seq_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.stb = 1'b0;
        unique case (s_q.st)
            SEQ_IDLE: begin
                if (start) begin
                    s_d.st = SEQ_CONV;
                    s_d.ch = 2'd0;
                end
            end
            SEQ_CONV: begin
                s_d.stb = 1'b1;
                s_d.cnt = 16'(SPACING - 1);
                s_d.st = (s_q.ch == 2'(NUM_CH - 1)) ? SEQ_IDLE : SEQ_GAP;
            end
            SEQ_GAP: begin
                if (s_q.cnt <= 16'd1) begin
                    s_d.st = SEQ_CONV;
                    s_d.ch = s_q.ch + 2'd1;
                end else begin
                    s_d.cnt = s_q.cnt - 16'd1;
                end
            end
            default: s_d.st = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '{st: SEQ_IDLE, cnt: 16'h0000, ch: 2'h0, stb: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = (s_q.st != SEQ_IDLE);
    assign conv_strobe = s_q.stb;
    assign conv_chan = s_q.ch;
endmodule : tdm_chan_seq
`default_nettype wire

// File: hdl/tdm_mode_ctrl.sv
// direct amplifier-to-converter mode control with ahb-lite register slave
//
// Function
// (RULE1) direct mode converts channels one to four, one microsecond apart
// (RULE2) routing 0xB065 bypasses filter and integrator, inverting drive
// (RULE3) routing 0xAE65 bypasses only the band-pass filter
// (RULE4) integrator buffers only when slot bit 7 and math bit 7 both set
// (RULE5) slot mode bit 9 selects buffer gain 1.0 or 0.7
// (RULE6) each slot chooses its analog path independently
// (RULE7) zero offset, default bias: output near 13000 codes, falls with current
// (RULE8) bias field bits 5:4 select amplifier reference voltage
// (RULE9) host sweeps timing offset to peak to check saturation
// (RULE10) host keeps readings at or below three quarters full scale
// (RULE11) host writes mode field bits 15:10 as 0x07 in normal mode
// (RULE12) slot settings latch at slot start, never mid conversion
//
// Our own choice: the AHB-Lite register port.
`default_nettype none
module tdm_mode_ctrl
    import tdm_pkg::*;
#(
    parameter int SPACING = CH_SPACING_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic slot_start_pin,
    input wire logic slot_sel_pin,
    output logic [1:0] amp_bias_reference,
    output logic slot_buffer_gain_select,
    output logic bpf_bypass,
    output logic int_bypass,
    output logic int_as_buffer,
    output logic conv_invert,
    output logic conv_strobe,
    output logic [1:0] conv_chan
);
    initial begin
        if (SPACING < 1) begin
            $error("spacing must be at least one cycle");
        end
    end

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [15:0] a_mode;
        logic [15:0] a_route;
        logic [15:0] b_mode;
        logic [15:0] b_route;
        logic [15:0] math;
        logic [1:0] sync_start;
        logic [1:0] sync_sel;
        logic start_old;
        logic act_slot;
        tdm_slot_cfg_s act;
        logic dp_wr;
        logic dp_rd;
        logic [7:0] dp_idx;
        logic [31:0] rdata;
        logic [15:0] slot_cnt;
    } tdm_ctrl_s;

    tdm_ctrl_s s_q;
    tdm_ctrl_s s_d;

    logic seq_busy;
    logic seq_start;

    // ************************************************************
    // decode functions
    // ************************************************************
    function automatic tdm_path_e route_decode(input logic [15:0] r);
        tdm_path_e p;
        p = PATH_NORMAL;
        // (RULE3) filter bypass code
        if (r == ROUTE_BYP_BPF) begin
            p = PATH_BYP_BPF;
        end
        // (RULE2) full bypass code
        if (r == ROUTE_BYP_ALL) begin
            p = PATH_BYP_ALL;
        end
        return p;
    endfunction : route_decode

    function automatic tdm_slot_cfg_s slot_decode(input logic [15:0] mode,
                                                   input logic [15:0] route,
                                                   input logic [15:0] math);
        tdm_slot_cfg_s c;
        c.path = route_decode(route);
        // (RULE4) both enables needed
        c.int_as_buf = mode[BIT_INT_AS_BUF] & math[BIT_ENA_BUF];
        // (RULE5) gain select bit
        c.gain_07 = mode[BIT_BUF_GAIN];
        // (RULE8) bias field
        c.bias_sel = mode[BIT_BIAS_LO +: 2];
        c.direct = (c.path != PATH_NORMAL);
        return c;
    endfunction : slot_decode

    function automatic logic [15:0] wr_merge(input logic [15:0] old,
                                             input logic [31:0] w);
        return w[15:0];
    endfunction : wr_merge

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        // pin synchronisers
        s_d.sync_start = {s_q.sync_start[0], slot_start_pin};
        s_d.sync_sel = {s_q.sync_sel[0], slot_sel_pin};
        s_d.start_old = s_q.sync_start[1];

        // ahb address phase
        s_d.dp_wr = 1'b0;
        s_d.dp_rd = 1'b0;
        if (hsel && hready && htrans[1]) begin
            s_d.dp_wr = hwrite;
            s_d.dp_rd = ~hwrite;
            s_d.dp_idx = haddr[9:2];
        end

        // ahb data phase write
        if (s_q.dp_wr) begin
            unique case (s_q.dp_idx)
                IDX_SLOT_A_MODE: s_d.a_mode = wr_merge(s_q.a_mode, hwdata);
                IDX_SLOT_A_ROUTE: s_d.a_route = wr_merge(s_q.a_route, hwdata);
                IDX_SLOT_B_MODE: s_d.b_mode = wr_merge(s_q.b_mode, hwdata);
                IDX_SLOT_B_ROUTE: s_d.b_route = wr_merge(s_q.b_route, hwdata);
                IDX_MATH_CTRL: s_d.math = wr_merge(s_q.math, hwdata);
                default: s_d.math = s_d.math;
            endcase
        end

        // read data prepared for next data phase
        s_d.rdata = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr[9:2])
                IDX_SLOT_A_MODE: s_d.rdata = {16'h0000, s_d.a_mode};
                IDX_SLOT_A_ROUTE: s_d.rdata = {16'h0000, s_d.a_route};
                IDX_SLOT_B_MODE: s_d.rdata = {16'h0000, s_d.b_mode};
                IDX_SLOT_B_ROUTE: s_d.rdata = {16'h0000, s_d.b_route};
                IDX_MATH_CTRL: s_d.rdata = {16'h0000, s_d.math};
                IDX_STATUS: s_d.rdata = {16'h0000, s_q.slot_cnt};
                IDX_SLOT_CTRL: s_d.rdata = {22'h00_0000, seq_busy, s_q.act_slot,
                                            s_q.act.direct, s_q.act.bias_sel,
                                            s_q.act.gain_07, s_q.act.int_as_buf,
                                            s_q.act.path, 1'b0};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end

        // (RULE12) latch on slot start
        if (seq_start) begin
            s_d.act_slot = s_q.sync_sel[1];
            // (RULE6) per-slot selection
            s_d.act = s_q.sync_sel[1] ? slot_decode(s_q.b_mode, s_q.b_route, s_q.math)
                                      : slot_decode(s_q.a_mode, s_q.a_route, s_q.math);
            s_d.slot_cnt = s_q.slot_cnt + 16'd1;
        end
    end

    // rising edge of synchronised slot start, ignored while sequencing
    assign seq_start = s_q.sync_start[1] & ~s_q.start_old & ~seq_busy;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '{a_mode: RST_MODE, a_route: RST_ROUTE,
                     b_mode: RST_MODE, b_route: RST_ROUTE,
                     math: RST_MATH, sync_start: 2'b00, sync_sel: 2'b00,
                     start_old: 1'b0, act_slot: 1'b0,
                     act: '{path: PATH_NORMAL, int_as_buf: 1'b0, gain_07: 1'b0,
                            bias_sel: 2'b00, direct: 1'b0},
                     dp_wr: 1'b0, dp_rd: 1'b0, dp_idx: 8'h00,
                     rdata: 32'h0000_0000, slot_cnt: 16'h0000};
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // channel sequencing
    // ************************************************************
    logic seq_go;
    // (RULE1) every slot start accepted while idle runs the channel sweep, direct or normal path
    assign seq_go = seq_start;

    tdm_chan_seq #(
        .SPACING(SPACING)
    ) u_seq (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(seq_go),
        .busy(seq_busy),
        .conv_strobe(conv_strobe),
        .conv_chan(conv_chan)
    );

    // ************************************************************
    // outputs
    // ************************************************************
    // (RULE2) bypass flags and inverting drive
    assign bpf_bypass = s_q.act.direct;
    assign int_bypass = (s_q.act.path == PATH_BYP_ALL);
    assign conv_invert = s_q.act.direct;
    // (RULE4) buffer only in filter-bypass path
    assign int_as_buffer = s_q.act.int_as_buf & (s_q.act.path == PATH_BYP_BPF);
    // (RULE5) gain to analog
    assign slot_buffer_gain_select = s_q.act.gain_07;
    // (RULE7) bias drives offset level
    assign amp_bias_reference = s_q.act.bias_sel;

    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule : tdm_mode_ctrl
`default_nettype wire

// File: dv/tdm_mode_ctrl_checker.sv
// assertion checker for the mode control block
`default_nettype none
module tdm_mode_ctrl_checker
    import tdm_pkg::*;
#(
    parameter int SPACING = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [1:0] amp_bias_reference,
    input wire logic slot_buffer_gain_select,
    input wire logic bpf_bypass,
    input wire logic int_bypass,
    input wire logic int_as_buffer,
    input wire logic conv_invert,
    input wire logic conv_strobe,
    input wire logic [1:0] conv_chan
);
    logic [6:0] cfg;
    assign cfg = {amp_bias_reference, slot_buffer_gain_select, bpf_bypass, int_bypass,
        int_as_buffer, conv_invert};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ****
    // assertions
    // ****
    a_bus_zero_wait: assert property (hreadyout && !hresp) else $error("bus not zero wait okay");
    a_invert_bpf: assert property (conv_invert == bpf_bypass)
        else $error("invert differs from filter bypass");
    a_full_bypass: assert property (int_bypass |-> bpf_bypass && !int_as_buffer)
        else $error("full bypass path wrong");
    a_buffer_path: assert property (int_as_buffer |-> bpf_bypass && !int_bypass)
        else $error("buffer without filter bypass");
    a_chan_step: assert property (conv_strobe && conv_chan != 2'h3 |-> ##SPACING
        (conv_strobe && conv_chan == $past(conv_chan, SPACING) + 2'h1))
        else $error("channel spacing wrong");
    a_strobe_pulse: assert property (conv_strobe |=> !conv_strobe)
        else $error("strobe longer than one cycle");
    a_sweep_end: assert property (conv_strobe && conv_chan == 2'h3 |=> !conv_strobe [*4])
        else $error("strobe after last channel");
    a_cfg_held: assert property (conv_strobe && conv_chan != 2'h3 |=> $stable(cfg) [*4])
        else $error("path changed mid sweep");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> cfg == 7'h00 && !conv_strobe)
        else $error("outputs active in reset");
    cover property (int_as_buffer && conv_strobe);
    cover property (int_bypass && conv_strobe);
    cover property (slot_buffer_gain_select && conv_chan == 2'h3);
endmodule : tdm_mode_ctrl_checker
bind tdm_mode_ctrl tdm_mode_ctrl_checker #(.SPACING(SPACING)) i_chk (.ref_clk, .rst,
    .hreadyout, .hresp, .amp_bias_reference, .slot_buffer_gain_select, .bpf_bypass,
    .int_bypass, .int_as_buffer, .conv_invert, .conv_strobe, .conv_chan);
`default_nettype wire

// File: dv/tdm_slot_gen.sv
// slot timing source: raises the slot start pin off the clock
`default_nettype none
module tdm_slot_gen (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic sel,
    output logic slot_start_pin,
    output logic slot_sel_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    initial slot_start_pin = 1'b0;
    initial slot_sel_pin = 1'b0;
    always @(posedge ref_clk) begin
        if (go) begin
            #1.3 slot_sel_pin = sel;
            slot_start_pin = 1'b1;
            repeat (3) @(posedge ref_clk);
            #2.1 slot_start_pin = 1'b0;
        end
    end
endmodule : tdm_slot_gen
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the mode control block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import tdm_pkg::*;
    logic ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, go = 0, sel = 0, s, ns;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, wd;
    logic [1:0] htrans = 0, conv_chan, bias;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, pin, psel, gain, bpf, intb, buf_o, inv, stb;
    logic [6:0] e;
    int num_errors = 0, cmp_count = 0;
    logic [31:0] seed = 32'h00002EE2;
    logic [15:0] mode_v [2], route_v [2], math_v;
    logic [7:0] idx_t [6] = '{IDX_SLOT_A_MODE, IDX_SLOT_A_ROUTE, IDX_SLOT_B_MODE,
        IDX_SLOT_B_ROUTE, IDX_MATH_CTRL, 8'h70};
    logic [15:0] rst_t [6] = '{RST_MODE, RST_ROUTE, RST_MODE, RST_ROUTE, RST_MATH, 16'h0};
    always #2.5 ref_clk = ~ref_clk;
    tdm_slot_gen i_tdm_slot_gen (.ref_clk, .go, .sel, .slot_start_pin(pin), .slot_sel_pin(psel));
    tdm_mode_ctrl #(.SPACING(4)) i_tdm_mode_ctrl (.ref_clk, .rst, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .slot_start_pin(pin), .slot_sel_pin(psel), .amp_bias_reference(bias),
        .slot_buffer_gain_select(gain), .bpf_bypass(bpf), .int_bypass(intb),
        .int_as_buffer(buf_o), .conv_invert(inv), .conv_strobe(stb), .conv_chan);
    // ****
    // helpers
    // ****
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [6:0] exp_out(logic [15:0] m, logic [15:0] r, logic mb);
        logic byp;
        byp = (r == ROUTE_BYP_BPF) || (r == ROUTE_BYP_ALL);
        return {m[5:4], m[9], byp, r == ROUTE_BYP_ALL, r == ROUTE_BYP_BPF && m[7] && mb, byp};
    endfunction : exp_out
    task automatic chk_reg(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_pin(logic [6:0] got, logic [6:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_pin
    task automatic ahb(logic w, logic [7:0] idx, logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        hsel <= 1'b0;
    endtask : ahb
    task automatic new_cfg(int i, logic t);
        logic [15:0] rt [4];
        logic [31:0] q;
        rt = '{ROUTE_NORMAL, ROUTE_BYP_BPF, ROUTE_BYP_ALL, 16'(rnd())};
        // buffer path picked every eighth config; no timing offset sweep here
        // no reading compared against full scale here
        mode_v[t] = 16'(rnd()) | (i % 8 == 1 ? 16'h0080 : 16'h0000);
        route_v[t] = rt[i % 4];
        math_v = 16'(rnd()) | (i % 8 == 1 ? 16'h0080 : 16'h0000);
        if (route_v[t] == ROUTE_NORMAL) mode_v[t][15:10] = 6'h07;
        ahb(1'b1, t ? IDX_SLOT_B_MODE : IDX_SLOT_A_MODE, {16'h0, mode_v[t]}, q);
        ahb(1'b1, t ? IDX_SLOT_B_ROUTE : IDX_SLOT_A_ROUTE, {16'h0, route_v[t]}, q);
        ahb(1'b1, IDX_MATH_CTRL, {16'h0, math_v}, q);
    endtask : new_cfg
    task automatic run_slot(logic t, logic [6:0] x);
        int n;
        n = 0;
        sel <= t;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (40) begin
            @(negedge ref_clk);
            if (stb === 1'b1) begin
                chk_pin({5'h0, conv_chan}, 7'(n));
                n++;
            end
        end
        chk_pin(7'(n), 7'h4);
        chk_pin({bias, gain, bpf, intb, buf_o, inv}, x);
    endtask : run_slot
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    // ****
    // sequence
    // ****
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (idx_t[k]) begin
            ahb(1'b0, idx_t[k], 32'h0, rd);
            chk_reg(rd, {16'h0, rst_t[k]});
            wd = rnd();
            ahb(1'b1, idx_t[k], wd, rd);
            ahb(1'b0, idx_t[k], 32'h0, rd);
            chk_reg(rd, k < 5 ? {16'h0, wd[15:0]} : 32'h0);
        end
        $display("register test done");
        new_cfg(0, 1'b1);
        s = 1'b0;
        new_cfg(0, s);
        for (int i = 1; i <= 12; i++) begin
            e = exp_out(mode_v[s], route_v[s], math_v[7]);
            ns = 1'(rnd());
            fork
                run_slot(s, e);
                begin
                    repeat (8) @(posedge ref_clk);
                    new_cfg(i, ns);
                end
            join
            s = ns;
            $display("slot run %0d done", i);
        end
        ahb(1'b0, IDX_STATUS, 32'h0, rd);
        chk_reg(rd, 32'h0000_000C);
        end_sim();
    end
    initial begin
        #50us;
        num_errors++;
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
